// ### common/bbc_pkg.sv
// Constants, carrier types and decode helpers for the bridge control block.
`default_nettype none
package bbc_pkg;

    // Configuration dword that holds the bridge control register.
    localparam logic [7:0] BBC_CTRL_DWORD = 8'h3C;
    localparam logic [7:0] BBC_CTRL_OFFSET = 8'h3E;
    // Byte lane (active-low enable index) that carries dword bits 23:16.
    localparam int BBC_CTRL_LANE = 2;
    localparam int BBC_PERR_RESP_POS = 16;
    localparam int BBC_SERR_FWD_POS = 17;
    localparam int BBC_ALIAS_POS = 18;
    localparam int BBC_LEGACY_POS = 19;
    localparam int BBC_RSVD_POS = 20;

    // Legacy display memory window, inclusive.
    localparam logic [31:0] BBC_VGA_MEM_LO = 32'h000A_0000;
    localparam logic [31:0] BBC_VGA_MEM_HI = 32'h000B_FFFF;
    // Legacy display I/O ranges on the low ten address bits, inclusive.
    localparam logic [9:0] BBC_VGA_IO_A_LO = 10'h3B0;
    localparam logic [9:0] BBC_VGA_IO_A_HI = 10'h3BB;
    localparam logic [9:0] BBC_VGA_IO_B_LO = 10'h3C0;
    localparam logic [9:0] BBC_VGA_IO_B_HI = 10'h3DF;
    // Address bits 31:16 value for the first 64KB of I/O space.
    localparam logic [15:0] BBC_IO_LOW64K = 16'h0000;
    // Start of the upper 768 bytes inside each 1KB block.
    localparam logic [9:0] BBC_ALIAS_LO = 10'h100;
    // Synchroniser value after reset; the serr pin idles high.
    localparam logic [1:0] BBC_SYNC_RST = 2'h3;

    typedef struct packed {
        logic legacy_display;
        logic alias_filter;
        logic serr_fwd;
        logic perr_resp;
    } bbc_ctrl_type;

    localparam bbc_ctrl_type BBC_CTRL_RST = '{legacy_display: 1'b0, alias_filter: 1'b0,
                                              serr_fwd: 1'b0, perr_resp: 1'b0};

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be_n;
        logic [31:0] wdata;
    } bbc_cfg_type;

    typedef struct packed {
        logic valid;
        logic is_io;
        logic is_mem;
        logic [31:0] addr;
    } bbc_req_type;

    typedef struct packed {
        logic [31:0] io_base;
        logic [31:0] io_limit;
        logic io_space_en;
        logic mem_space_en;
        logic serr_drv_en;
    } bbc_cmd_type;

    typedef struct packed {
        bbc_ctrl_type ctrl;
        logic [31:0] cfg_rdata;
        logic cfg_rvalid;
        logic pri_done;
        logic pri_fwd;
        logic sec_done;
        logic sec_fwd;
        logic s_perr_l_o;
        logic s_perr_l_oe;
        logic dpr_set;
        logic p_serr_l_o;
        logic p_serr_l_oe;
        logic s_serr_seen;
    } bbc_state_type;

    function automatic logic bbc_in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        bbc_in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic bbc_vga_io_hit(input logic [31:0] a);
        bbc_vga_io_hit = (a[31:16] == BBC_IO_LOW64K) &&
                         (((a[9:0] >= BBC_VGA_IO_A_LO) && (a[9:0] <= BBC_VGA_IO_A_HI)) ||
                          ((a[9:0] >= BBC_VGA_IO_B_LO) && (a[9:0] <= BBC_VGA_IO_B_HI)));
    endfunction

    function automatic logic bbc_alias_hit(input logic [31:0] a);
        bbc_alias_hit = (a[31:16] == BBC_IO_LOW64K) && (a[9:0] >= BBC_ALIAS_LO);
    endfunction

endpackage
`default_nettype wire

// ### rtl/bbc_decode.sv
// Forwarding decision for one transaction, downstream and upstream views.
`timescale 1ns/1ps
`default_nettype none
module bbc_decode
    import bbc_pkg::*;
(
    input wire bbc_req_type req, // Transaction address and type.
    input wire bbc_cmd_type cmd, // Window and command enables.
    input wire bbc_ctrl_type ctrl, // Bridge control bits.
    output logic down_fwd, // Claim as seen from the primary bus.
    output logic up_fwd // Claim as seen from the secondary bus.
);

    logic in_win;
    logic alias_blk;
    logic legacy_on;
    logic vga_io;
    logic vga_mem;

    always_comb begin
        in_win = bbc_in_range(req.addr, cmd.io_base, cmd.io_limit);
        // The filter only touches window addresses in the first 64KB.
        alias_blk = ctrl.alias_filter && in_win && bbc_alias_hit(req.addr);
        // Legacy display decode needs both space enables.
        legacy_on = ctrl.legacy_display && cmd.io_space_en && cmd.mem_space_en;
        vga_io = legacy_on && bbc_vga_io_hit(req.addr);
        vga_mem = legacy_on && bbc_in_range(req.addr, BBC_VGA_MEM_LO, BBC_VGA_MEM_HI);
        down_fwd = 1'b0;
        up_fwd = 1'b0;
        if (req.is_io) begin
            // Window forwarding, less aliases, plus forced legacy I/O.
            down_fwd = (cmd.io_space_en && in_win && !alias_blk) || vga_io;
            // Outside the window goes up; filtered aliases go up too.
            up_fwd = (!in_win || alias_blk) && !vga_io;
        end else if (req.is_mem) begin
            // Memory windows live elsewhere; only the legacy range is claimed here.
            down_fwd = vga_mem;
            up_fwd = !vga_mem;
        end
    end

endmodule
`default_nettype wire

// ### rtl/bbc_sync.sv
// Two-flop synchroniser for an asynchronous pin level.
`timescale 1ns/1ps
`default_nettype none
module bbc_sync
    import bbc_pkg::*;
(
    input wire logic clk, // Core clock.
    input wire logic reset, // Asynchronous reset, active high.
    input wire logic d, // Asynchronous input level.
    output logic q // Synchronised level.
);

    typedef struct packed {
        logic [1:0] stage;
    } bbc_sync_state_type;

    bbc_sync_state_type st_r;
    bbc_sync_state_type st_nxt;

    always_comb begin
        st_nxt.stage = {st_r.stage[0], d};
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r.stage <= BBC_SYNC_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.stage[1];

endmodule
`default_nettype wire

// ### rtl/bbc_top.sv
// Bridge control register bits 16 to 20 with error forwarding and legacy decode.
//
// Function
// - With parity error response clear the secondary parity line and the reported flag stay quiet.
// - With parity error response set a secondary data parity error drives the parity line and sets the flag.
// - A secondary address parity error raises primary serr only while parity error response is set.
// - With serr forwarding clear a secondary serr never raises primary serr.
// - With serr forwarding set a secondary serr raises primary serr if the command serr driver is enabled.
// - The alias filter only affects window addresses inside the first 64KB and resets to zero.
// - With the alias filter clear every I/O access inside the window goes downstream while I/O space is enabled.
// - With the alias filter set primary window accesses to the upper 768 bytes of each 1KB in the first 64KB are ignored unless legacy display claims them.
// - With the alias filter set secondary accesses to the upper 768 bytes of each 1KB in the first 64KB go upstream unless legacy display claims them.
// - With legacy display clear legacy accesses are claimed only through the window with the filter clear.
// - With legacy display set the legacy memory range is claimed regardless of windows and filter.
// - With legacy display set the two legacy I/O ranges are claimed with bits 31:16 zero.
// - Legacy display forwarding needs both I/O and memory space enables.
// - With legacy display on, secondary accesses to the legacy ranges are not forwarded upstream.
// - Bit 20 is reserved and reads as zero.
`timescale 1ns/1ps
`default_nettype none
module bbc_top
    import bbc_pkg::*;
(
    input wire logic clk, // 20 MHz core clock.
    input wire logic reset, // Asynchronous reset, active high.
    input wire bbc_cfg_type cfg, // Configuration access strobe, address, enables, data.
    output logic [31:0] cfg_rdata, // Read data for the control dword.
    output logic cfg_rvalid, // One-cycle pulse marking cfg_rdata.
    input wire bbc_cmd_type cmd, // Window registers and command enables.
    output logic [3:0] ctrl_bits, // Current control bits 19:16.
    input wire bbc_req_type pri_req, // Primary bus decode request.
    output logic pri_done, // Pulse, primary decode answered.
    output logic pri_fwd, // Primary transaction claimed downstream.
    input wire bbc_req_type sec_req, // Secondary bus decode request.
    output logic sec_done, // Pulse, secondary decode answered.
    output logic sec_fwd, // Secondary transaction claimed upstream.
    input wire logic sec_data_perr, // Pulse, data parity error seen on secondary.
    input wire logic sec_addr_perr, // Pulse, address parity error seen on secondary.
    input wire logic s_serr_l, // Secondary serr pin, active low.
    output logic s_perr_l_o, // Secondary perr drive level.
    output logic s_perr_l_oe, // Secondary perr output enable.
    output logic dpr_set, // Pulse, set data parity reported in secondary status.
    output logic p_serr_l_o, // Primary serr drive level.
    output logic p_serr_l_oe // Primary serr output enable, open drain.
);

    bbc_state_type st_r;
    bbc_state_type st_nxt;
    logic s_serr_l_sync;
    logic pri_down;
    logic sec_up;
    logic cfg_hit;
    logic serr_new;

    bbc_sync u_serr_sync (
        .clk(clk),
        .reset(reset),
        .d(s_serr_l),
        .q(s_serr_l_sync)
    );

    bbc_decode u_pri_decode (
        .req(pri_req),
        .cmd(cmd),
        .ctrl(st_r.ctrl),
        .down_fwd(pri_down),
        .up_fwd()
    );

    bbc_decode u_sec_decode (
        .req(sec_req),
        .cmd(cmd),
        .ctrl(st_r.ctrl),
        .down_fwd(),
        .up_fwd(sec_up)
    );

    always_comb begin
        st_nxt = st_r;
        cfg_hit = (cfg.addr == BBC_CTRL_DWORD);

        // Only the lane holding bits 23:16 has storage; bits 31:21 belong elsewhere.
        if (cfg.wr && cfg_hit && !cfg.be_n[BBC_CTRL_LANE]) begin
            st_nxt.ctrl.perr_resp = cfg.wdata[BBC_PERR_RESP_POS];
            st_nxt.ctrl.serr_fwd = cfg.wdata[BBC_SERR_FWD_POS];
            st_nxt.ctrl.alias_filter = cfg.wdata[BBC_ALIAS_POS];
            st_nxt.ctrl.legacy_display = cfg.wdata[BBC_LEGACY_POS];
        end

        st_nxt.cfg_rvalid = cfg.rd && cfg_hit;
        st_nxt.cfg_rdata = 32'h0000_0000;
        if (cfg.rd && cfg_hit) begin
            st_nxt.cfg_rdata[BBC_PERR_RESP_POS] = st_r.ctrl.perr_resp;
            st_nxt.cfg_rdata[BBC_SERR_FWD_POS] = st_r.ctrl.serr_fwd;
            st_nxt.cfg_rdata[BBC_ALIAS_POS] = st_r.ctrl.alias_filter;
            st_nxt.cfg_rdata[BBC_LEGACY_POS] = st_r.ctrl.legacy_display;
            st_nxt.cfg_rdata[BBC_RSVD_POS] = 1'b0;
        end

        st_nxt.pri_done = pri_req.valid;
        st_nxt.pri_fwd = pri_req.valid && pri_down;
        st_nxt.sec_done = sec_req.valid;
        st_nxt.sec_fwd = sec_req.valid && sec_up;

        // Parity line and status flag both stay quiet unless the response bit is set.
        st_nxt.s_perr_l_oe = sec_data_perr && st_r.ctrl.perr_resp;
        st_nxt.s_perr_l_o = !(sec_data_perr && st_r.ctrl.perr_resp);
        st_nxt.dpr_set = sec_data_perr && st_r.ctrl.perr_resp;

        // A held low serr pin forwards once; a new pulse needs the pin to rise first.
        st_nxt.s_serr_seen = !s_serr_l_sync;
        serr_new = !s_serr_l_sync && !st_r.s_serr_seen;
        st_nxt.p_serr_l_oe = cmd.serr_drv_en &&
                             ((serr_new && st_r.ctrl.serr_fwd) ||
                              (sec_addr_perr && st_r.ctrl.perr_resp));
        st_nxt.p_serr_l_o = !st_nxt.p_serr_l_oe;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r.ctrl <= BBC_CTRL_RST;
            st_r.cfg_rdata <= 32'h0000_0000;
            st_r.cfg_rvalid <= 1'b0;
            st_r.pri_done <= 1'b0;
            st_r.pri_fwd <= 1'b0;
            st_r.sec_done <= 1'b0;
            st_r.sec_fwd <= 1'b0;
            st_r.s_perr_l_o <= 1'b1;
            st_r.s_perr_l_oe <= 1'b0;
            st_r.dpr_set <= 1'b0;
            st_r.p_serr_l_o <= 1'b1;
            st_r.p_serr_l_oe <= 1'b0;
            st_r.s_serr_seen <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cfg_rdata = st_r.cfg_rdata;
    assign cfg_rvalid = st_r.cfg_rvalid;
    assign ctrl_bits = st_r.ctrl;
    assign pri_done = st_r.pri_done;
    assign pri_fwd = st_r.pri_fwd;
    assign sec_done = st_r.sec_done;
    assign sec_fwd = st_r.sec_fwd;
    assign s_perr_l_o = st_r.s_perr_l_o;
    assign s_perr_l_oe = st_r.s_perr_l_oe;
    assign dpr_set = st_r.dpr_set;
    assign p_serr_l_o = st_r.p_serr_l_o;
    assign p_serr_l_oe = st_r.p_serr_l_oe;

endmodule
`default_nettype wire

// ### verif/bbc_agent.sv
// Secondary bus agent that pulls the shared serr line low on command.
`timescale 1ns/1ps
`default_nettype none
module bbc_agent (
    input wire logic clk, // Bus clock.
    input wire logic go, // Request one serr assertion.
    input wire logic [3:0] len, // Cycles to hold the line low.
    output logic s_serr_l // Serr line, pulled up when released.
);
    initial s_serr_l = 1'b1;
    // The odd offset keeps the pin change unrelated to the sampling edge, as a real agent would be.
    always @(posedge clk) begin
        if (go) begin
            #13 s_serr_l = 1'b0;
            repeat (len) @(posedge clk);
            #13 s_serr_l = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### verif/bbc_properties.sv
// Port-level assertions for the bridge control block.
`timescale 1ns/1ps
`default_nettype none
module bbc_properties
    import bbc_pkg::*;
(
    input wire logic clk, // Core clock.
    input wire logic reset, // Asynchronous reset.
    input wire bbc_cfg_type cfg, // Configuration access.
    input wire logic [31:0] cfg_rdata, // Read data.
    input wire logic cfg_rvalid, // Read data marker.
    input wire bbc_cmd_type cmd, // Command enables.
    input wire logic [3:0] ctrl_bits, // Control bits.
    input wire bbc_req_type pri_req, // Primary request.
    input wire logic pri_done, // Primary answer.
    input wire logic pri_fwd, // Primary claim.
    input wire logic sec_data_perr, // Data parity error.
    input wire logic sec_addr_perr, // Address parity error.
    input wire logic s_serr_l, // Secondary serr pin.
    input wire logic s_perr_l_o, // Perr level.
    input wire logic s_perr_l_oe, // Perr enable.
    input wire logic dpr_set, // Reported flag pulse.
    input wire logic p_serr_l_o, // Primary serr level.
    input wire logic p_serr_l_oe // Primary serr enable.
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic vga_mem;
    assign vga_mem = ctrl_bits[3] && cmd.io_space_en && cmd.mem_space_en && !pri_req.is_io &&
                     pri_req.addr >= BBC_VGA_MEM_LO && pri_req.addr <= BBC_VGA_MEM_HI;
    a_perr_quiet: assert property (sec_data_perr && !ctrl_bits[0] |=> !s_perr_l_oe && !dpr_set)
        else $error("parity line driven while response is off");
    a_perr_drive: assert property (sec_data_perr && ctrl_bits[0] |=> s_perr_l_oe && !s_perr_l_o && dpr_set)
        else $error("parity error not reported");
    a_addr_perr: assert property (sec_addr_perr && ctrl_bits[0] && cmd.serr_drv_en |=> p_serr_l_oe && !p_serr_l_o)
        else $error("address parity error not signalled");
    a_serr_fwd: assert property ($fell(s_serr_l) ##2 (ctrl_bits[1] && cmd.serr_drv_en) |=> p_serr_l_oe && !p_serr_l_o)
        else $error("secondary serr not forwarded");
    a_serr_cause: assert property (p_serr_l_oe |-> $past(cmd.serr_drv_en) && ($past(sec_addr_perr && ctrl_bits[0]) || $past(ctrl_bits[1])))
        else $error("primary serr without enabled cause");
    a_rd_answer: assert property (cfg.rd && cfg.addr == BBC_CTRL_DWORD |=> cfg_rdata == {12'h000, $past(ctrl_bits), 16'h0000})
        else $error("read data wrong");
    a_rd_only: assert property (cfg_rvalid == $past(cfg.rd && cfg.addr == BBC_CTRL_DWORD))
        else $error("read answer at wrong time");
    a_lane_write: assert property (cfg.wr && cfg.addr == BBC_CTRL_DWORD |=>
        ctrl_bits == ($past(cfg.be_n[2]) ? $past(ctrl_bits) : $past(cfg.wdata[19:16])))
        else $error("control write lane handling wrong");
    a_legacy_mem: assert property (pri_req.valid && pri_req.is_mem |=> pri_done && pri_fwd == $past(vga_mem))
        else $error("legacy memory claim wrong");
endmodule
bind bbc_top bbc_properties i_bbc_properties (.clk, .reset, .cfg, .cfg_rdata, .cfg_rvalid, .cmd, .ctrl_bits,
    .pri_req, .pri_done, .pri_fwd, .sec_data_perr, .sec_addr_perr, .s_serr_l, .s_perr_l_o, .s_perr_l_oe,
    .dpr_set, .p_serr_l_o, .p_serr_l_oe);
`default_nettype wire

// ### verif/bbc_top_bench.sv
// Self-checking bench for the bridge control block.
`timescale 1ns/1ps
`default_nettype none
module bbc_top_bench
    import bbc_pkg::*;
;
    logic clk = 1'b0, reset = 1'b1, sec_data_perr = 1'b0, sec_addr_perr = 1'b0, go = 1'b0;
    bbc_cfg_type cfg = '0;
    bbc_cmd_type cmd = '0;
    bbc_req_type pri_req = '0, sec_req = '0, r;
    logic [3:0] len = 4'h3, cr = 4'h0, ctrl_bits;
    logic [31:0] cfg_rdata, rq[$];
    logic cfg_rvalid, pri_done, pri_fwd, sec_done, sec_fwd, s_serr_l, s_perr_l_o, s_perr_l_oe;
    logic dpr_set, p_serr_l_o, p_serr_l_oe, pq[$], sq[$], eq_perr[$], eq_serr[$];
    int fail_count = 0, samples_checked = 0;
    always #25 clk = ~clk;
    bbc_top i_bbc_top (.clk, .reset, .cfg, .cfg_rdata, .cfg_rvalid, .cmd, .ctrl_bits, .pri_req, .pri_done,
        .pri_fwd, .sec_req, .sec_done, .sec_fwd, .sec_data_perr, .sec_addr_perr, .s_serr_l, .s_perr_l_o,
        .s_perr_l_oe, .dpr_set, .p_serr_l_o, .p_serr_l_oe);
    bbc_agent i_bbc_agent (.clk, .go, .len, .s_serr_l);
    task chk(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wrap_up;
        if (fail_count == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task tick;
        @(posedge clk);
        #1;
    endtask
    task wr(logic [7:0] a, logic [3:0] b, logic [31:0] d);
        cfg = '{wr: 1'b1, rd: 1'b0, addr: a, be_n: b, wdata: d};
        if (a == 8'h3C && !b[2]) cr = d[19:16];
        tick;
        cfg.wr = 1'b0;
        // One idle edge keeps a following access from raising a strobe in the step that lowered it.
        tick;
    endtask
    task rd(logic [7:0] a);
        cfg.rd = 1'b1;
        cfg.addr = a;
        if (a == 8'h3C) rq.push_back({12'h000, cr, 16'h0000});
        tick;
        cfg.rd = 1'b0;
        tick;
    endtask
    function automatic logic ef(logic up, bbc_req_type q);
        logic w, al, vi, vm, lg;
        lg = cr[3] & cmd.io_space_en & cmd.mem_space_en;
        w = q.addr >= cmd.io_base && q.addr <= cmd.io_limit;
        al = cr[2] & w & q.addr[31:16] == 16'h0000 & q.addr[9:0] >= 10'h100;
        vi = q.addr[31:16] == 16'h0000 && q.addr[9:0] inside {[10'h3B0:10'h3BB], [10'h3C0:10'h3DF]};
        vm = q.addr inside {[32'h000A_0000:32'h000B_FFFF]};
        if (q.is_io) return up ? (!w | al) & !(lg & vi) : (cmd.io_space_en & w & !al) | (lg & vi);
        if (q.is_mem) return up ? !(lg & vm) : lg & vm;
        return 1'b0;
    endfunction
    function automatic int pend();
        return rq.size() + pq.size() + sq.size() + eq_perr.size() + eq_serr.size();
    endfunction
    always @(negedge clk) begin
        if (cfg_rvalid === 1'b1) chk("cfg_rdata", cfg_rdata, rq.size() ? rq.pop_front() : 'x);
        if (pri_done === 1'b1) chk("pri_fwd", pri_fwd, pq.size() ? pq.pop_front() : 1'bx);
        if (sec_done === 1'b1) chk("sec_fwd", sec_fwd, sq.size() ? sq.pop_front() : 1'bx);
        if (s_perr_l_oe === 1'b1) chk("perr", {dpr_set, s_perr_l_o}, eq_perr.size() ? 2'h2 : 2'bxx);
        if (s_perr_l_oe === 1'b1 && eq_perr.size()) void'(eq_perr.pop_front());
        if (p_serr_l_oe === 1'b1) chk("p_serr", p_serr_l_o, eq_serr.size() ? eq_serr.pop_front() : 1'bx);
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        wrap_up;
    end
    initial begin
        void'($urandom(32'hC82E));
        repeat (20) @(posedge clk);
        #1 reset = 1'b0;
        tick;
        rd(8'h3C);
        wr(8'h3C, 4'hF, 32'hFFFF_FFFF);
        rd(8'h3C);
        wr(8'h40, 4'h0, 32'hFFFF_FFFF);
        rd(8'h40);
        wr(8'h3C, 4'hB, 32'h001F_0000);
        rd(8'h3C);
        for (int k = 0; k < 8; k++) begin
            // Software sets the register before relying on error reporting.
            wr(8'h3C, 4'hB, {12'h000, 2'b00, k[1:0], 16'h0000});
            cmd.serr_drv_en = k[2];
            sec_data_perr = 1'b1;
            if (cr[0]) eq_perr.push_back(1'b1);
            tick;
            sec_data_perr = 1'b0;
            sec_addr_perr = 1'b1;
            if (cr[0] && k[2]) eq_serr.push_back(1'b0);
            tick;
            sec_addr_perr = 1'b0;
            go = 1'b1;
            len = 4'(2 + k);
            if (cr[1] && k[2]) eq_serr.push_back(1'b0);
            tick;
            go = 1'b0;
            repeat (14) tick;
        end
        cmd.io_base = 32'h0000_1000;
        cmd.io_limit = 32'h0000_1FFF;
        for (int n = 0; n < 400; n++) begin
            if (n % 25 == 0) begin
                pri_req.valid = 1'b0;
                sec_req.valid = 1'b0;
                wr(8'h3C, 4'hB, {12'h000, 4'($urandom), 16'h0000});
            end
            cmd.io_space_en = $urandom % 4 != 0;
            cmd.mem_space_en = $urandom % 4 != 0;
            r.valid = 1'b1;
            r.is_io = 1'($urandom);
            r.is_mem = !r.is_io && $urandom % 8 != 0;
            r.addr = {($urandom % 8 == 0) ? 16'h0001 : 16'h0000, 3'b000, 3'($urandom),
                      $urandom % 2 ? 10'h3B0 + 10'($urandom % 64) : 10'($urandom)};
            if (!r.is_io) r.addr = 32'h0009_0000 + $urandom % 32'h0004_0000;
            pri_req = r;
            sec_req = r;
            pq.push_back(ef(1'b0, r));
            sq.push_back(ef(1'b1, r));
            tick;
        end
        pri_req.valid = 1'b0;
        sec_req.valid = 1'b0;
        for (int i = 0; i < 20 && pend() > 0; i++) tick;
        chk("pending", pend(), 0);
        wrap_up;
    end
endmodule
`default_nettype wire
